// ---- logic/cfi_pkg.sv ----
// Constants for the CPU frame injection header path.
// Assumes an APB register bus with 32-bit data and byte addresses.
package cfi_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [11:0] CFI_OFS_CTRL = 12'h000;
    localparam logic [11:0] CFI_OFS_STAG = 12'h004;
    localparam logic [11:0] CFI_OFS_STATUS = 12'h008;

    // Control register fields
    localparam int CFI_CTRL_HDR0_BIT = 0;
    localparam int CFI_CTRL_HDR1_BIT = 1;
    localparam int CFI_CTRL_PRIO_BIT = 2;
    localparam int CFI_CTRL_CUSTOM_BIT = 3;
    localparam logic [3:0] CFI_CTRL_RESET = 4'h0;

    // Status register fields
    localparam int CFI_STAT_CNT0_LSB = 0;
    localparam int CFI_STAT_CNT1_LSB = 8;
    localparam int CFI_STAT_SHORT_LSB = 16;
    localparam int CFI_STAT_BUSY_LSB = 24;

    // ==========================================================
    // Injection header layout
    // ==========================================================
    localparam int CFI_HDR_BYTES = 8;
    localparam logic [2:0] CFI_HDR_LAST = 3'h7;
    localparam int CFI_BYPASS_BIT = 63;
    localparam int CFI_TSET_LSB = 32;
    localparam int CFI_TSET_W = 27;
    localparam int CFI_TSET_CPU_BIT = 58;
    localparam int CFI_STRIP_LSB = 28;
    localparam int CFI_QMASK_LSB = 20;
    localparam int CFI_CLASS_LSB = 17;
    localparam int CFI_TAGTYPE_BIT = 16;
    localparam int CFI_PCP_LSB = 13;
    localparam int CFI_DEI_BIT = 12;
    localparam int CFI_VID_LSB = 0;
    localparam logic [1:0] CFI_STRIP_NOREWRITE = 2'h3;

    // ==========================================================
    // Tag protocol identifiers and port numbers
    // ==========================================================
    localparam logic [15:0] CFI_TPID_CTAG = 16'h8100;
    localparam logic [15:0] CFI_TPID_STAG = 16'h88a8;
    localparam logic [4:0] CFI_CORE_PORT = 5'h1a;
    localparam logic [4:0] CFI_PORT_GRP0 = 5'h1a;
    localparam logic [4:0] CFI_PORT_GRP1 = 5'h1b;

    // Parser states
    typedef enum logic [1:0] {
        CFI_ST_IDLE = 2'b00,
        CFI_ST_HDR = 2'b01,
        CFI_ST_BODY = 2'b10
    } cfi_state_t;

endpackage : cfi_pkg

// ---- logic/cfi_hdr_parser.sv ----
// One injection group: strips and holds the leading injection header.
// Assumes byte stream input with valid/ready and start/end markers.
`timescale 1ns/10ps
module cfi_hdr_parser
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic hdr_enable,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    input wire logic in_sop,
    input wire logic in_eop,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data,
    output logic out_sop,
    output logic out_eop,
    output logic [63:0] hdr_word,
    output logic hdr_used,
    output logic short_pulse,
    output logic busy
);
    // ==========================================================
    // State
    // ==========================================================
    cfi_pkg::cfi_state_t state_r, state_nxt;
    logic [63:0] hdr_r, hdr_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic used_r, used_nxt;
    logic first_r, first_nxt;
    logic short_nxt;

    // Next-state and stream steering
    always_comb
    begin
        state_nxt = state_r;
        hdr_nxt = hdr_r;
        cnt_nxt = cnt_r;
        used_nxt = used_r;
        first_nxt = first_r;
        short_nxt = 1'b0;
        in_ready = 1'b1;
        out_valid = 1'b0;
        case (state_r)
            cfi_pkg::CFI_ST_IDLE:
            begin
                if (in_valid && in_sop)
                begin
                    used_nxt = hdr_enable;
                    if (hdr_enable)
                    begin
                        // First byte is header bits 63..56
                        hdr_nxt = {hdr_r[55:0], in_data};
                        cnt_nxt = 3'h1;
                        if (in_eop)
                            short_nxt = 1'b1;
                        else
                            state_nxt = cfi_pkg::CFI_ST_HDR;
                    end
                    else
                    begin
                        // No header: hold the byte for the body path
                        in_ready = 1'b0;
                        first_nxt = 1'b1;
                        state_nxt = cfi_pkg::CFI_ST_BODY;
                    end
                end
            end
            cfi_pkg::CFI_ST_HDR:
            begin
                if (in_valid)
                begin
                    hdr_nxt = {hdr_r[55:0], in_data};
                    cnt_nxt = cnt_r + 3'h1;
                    if (in_eop)
                    begin
                        short_nxt = 1'b1;
                        state_nxt = cfi_pkg::CFI_ST_IDLE;
                    end
                    else if (cnt_r == cfi_pkg::CFI_HDR_LAST)
                    begin
                        first_nxt = 1'b1;
                        state_nxt = cfi_pkg::CFI_ST_BODY;
                    end
                end
            end
            cfi_pkg::CFI_ST_BODY:
            begin
                out_valid = in_valid;
                in_ready = out_ready;
                if (in_valid && out_ready)
                begin
                    first_nxt = 1'b0;
                    if (in_eop)
                        state_nxt = cfi_pkg::CFI_ST_IDLE;
                end
            end
            default:
            begin
                state_nxt = cfi_pkg::CFI_ST_IDLE;
            end
        endcase
    end

    // Registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= cfi_pkg::CFI_ST_IDLE;
            hdr_r <= 64'h0;
            cnt_r <= 3'h0;
            used_r <= 1'b0;
            first_r <= 1'b0;
            short_pulse <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            hdr_r <= hdr_nxt;
            cnt_r <= cnt_nxt;
            used_r <= used_nxt;
            first_r <= first_nxt;
            short_pulse <= short_nxt;
        end
    end

    // Body pass-through
    assign out_data = in_data;
    assign out_sop = first_r;
    assign out_eop = in_eop;
    assign hdr_word = hdr_r;
    assign hdr_used = used_r;
    assign busy = (state_r != cfi_pkg::CFI_ST_IDLE);

endmodule : cfi_hdr_parser

// ---- logic/cfi_top.sv ----
// CPU frame injection: two groups, header decode, merge into the core.
// Assumes APB master on pclk and a core sink with valid/ready.
`timescale 1ns/10ps

// Functional notes
// - Two injection groups run independently, one per CPU port 26/27.
// - Every injected frame enters the core as if received on port 26.
// - The CPU source priority setting makes the core prefer the CPU.
// - The first eight bytes of each frame are a side-band header.
// - Bit 63 set skips the analyzer and uses the header fields.
// - Bit 63 clear leaves forwarding and tagging to the analyzer.
// - A 27-bit target set at bit 32, top bit the CPU, used on bypass.
// - Strip count at bit 28 pops 0-2 tags; 3 disables tag rewriting.
// - Queue mask at bit 20 applies only on bypass with CPU target.
// - The 3-bit class at bit 17 is the forwarding class on bypass.
// - Bit 16 picks C-tag 0x8100 or S-tag 0x88a8 or a custom TPID.
// - PCP at 13, DEI at 12 and VID at 0 are the classified tag.
module cfi_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic inj0_valid,
    output logic inj0_ready,
    input wire logic [7:0] inj0_data,
    input wire logic inj0_sop,
    input wire logic inj0_eop,
    input wire logic inj1_valid,
    output logic inj1_ready,
    input wire logic [7:0] inj1_data,
    input wire logic inj1_sop,
    input wire logic inj1_eop,
    output logic core_valid,
    input wire logic core_ready,
    output logic [7:0] core_data,
    output logic core_sop,
    output logic core_eop,
    output logic [4:0] core_src_port,
    output logic [4:0] core_cpu_port,
    output logic core_use_analyzer,
    output logic core_bypass,
    output logic [26:0] core_target_port_set,
    output logic [7:0] core_queue_mask,
    output logic [2:0] core_service_class_override,
    output logic [1:0] core_tag_strip_count,
    output logic core_rewrite_off,
    output logic core_tag_s,
    output logic [15:0] core_tpid,
    output logic [2:0] core_pcp,
    output logic core_dei,
    output logic [11:0] core_vid,
    output logic cpu_source_priority
);
    // ==========================================================
    // Register file over APB
    // ==========================================================
    logic [3:0] ctrl_r, ctrl_nxt;
    logic [15:0] stag_r, stag_nxt;
    logic [7:0] cnt0_r, cnt0_nxt;
    logic [7:0] cnt1_r, cnt1_nxt;
    logic [7:0] short_r, short_nxt;
    logic wr_en;
    logic mapped;
    logic [1:0] pbusy;
    logic [1:0] pshort;

    assign wr_en = psel && penable && pwrite;
    assign pready = 1'b1;

    // Address decode and read mux
    always_comb
    begin
        prdata = 32'h0;
        mapped = 1'b1;
        if (paddr == cfi_pkg::CFI_OFS_CTRL)
            prdata = {28'h0, ctrl_r};
        else if (paddr == cfi_pkg::CFI_OFS_STAG)
            prdata = {16'h0, stag_r};
        else if (paddr == cfi_pkg::CFI_OFS_STATUS)
            prdata = {6'h0, pbusy, short_r, cnt1_r, cnt0_r};
        else
            mapped = 1'b0;
    end

    assign pslverr = psel && penable && !mapped;

    // Writable configuration
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        stag_nxt = stag_r;
        if (wr_en && paddr == cfi_pkg::CFI_OFS_CTRL)
            ctrl_nxt = pwdata[3:0];
        if (wr_en && paddr == cfi_pkg::CFI_OFS_STAG)
            stag_nxt = pwdata[15:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= cfi_pkg::CFI_CTRL_RESET;
            stag_r <= cfi_pkg::CFI_TPID_STAG;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            stag_r <= stag_nxt;
        end
    end

    // Level to the queue system
    assign cpu_source_priority = ctrl_r[cfi_pkg::CFI_CTRL_PRIO_BIT];

    // ==========================================================
    // Injection groups
    // ==========================================================
    logic [1:0] pv, pready_in, psop, peop, hused;
    logic [7:0] pdata [2];
    logic [63:0] phdr [2];

    // Group for CPU port 26
    cfi_hdr_parser u_grp0
    (
        .pclk(pclk),
        .presetn(presetn),
        .hdr_enable(ctrl_r[cfi_pkg::CFI_CTRL_HDR0_BIT]),
        .in_valid(inj0_valid),
        .in_ready(inj0_ready),
        .in_data(inj0_data),
        .in_sop(inj0_sop),
        .in_eop(inj0_eop),
        .out_valid(pv[0]),
        .out_ready(pready_in[0]),
        .out_data(pdata[0]),
        .out_sop(psop[0]),
        .out_eop(peop[0]),
        .hdr_word(phdr[0]),
        .hdr_used(hused[0]),
        .short_pulse(pshort[0]),
        .busy(pbusy[0])
    );

    // Group for CPU port 27
    cfi_hdr_parser u_grp1
    (
        .pclk(pclk),
        .presetn(presetn),
        .hdr_enable(ctrl_r[cfi_pkg::CFI_CTRL_HDR1_BIT]),
        .in_valid(inj1_valid),
        .in_ready(inj1_ready),
        .in_data(inj1_data),
        .in_sop(inj1_sop),
        .in_eop(inj1_eop),
        .out_valid(pv[1]),
        .out_ready(pready_in[1]),
        .out_data(pdata[1]),
        .out_sop(psop[1]),
        .out_eop(peop[1]),
        .hdr_word(phdr[1]),
        .hdr_used(hused[1]),
        .short_pulse(pshort[1]),
        .busy(pbusy[1])
    );

    // ==========================================================
    // Frame arbiter and output stage
    // ==========================================================
    logic lock_r, lock_nxt, owner_r, owner_nxt, last_r, last_nxt;
    logic grant, load, take;
    logic ov_r, ov_nxt, osop_r, osop_nxt, oeop_r, oeop_nxt;
    logic [7:0] odata_r, odata_nxt;
    logic ogrp_r, ogrp_nxt;
    logic [63:0] h;
    logic byp;
    logic [36:0] desc_r, desc_nxt;
    logic [15:0] tpid_r, tpid_nxt;

    assign load = !ov_r || core_ready;
    assign h = phdr[grant];
    // Reserved header bits are never looked at
    assign byp = hused[grant] && h[cfi_pkg::CFI_BYPASS_BIT];

    // Frame-level round robin, locked until end of frame
    always_comb
    begin
        grant = owner_r;
        if (!lock_r)
            grant = (pv[0] && pv[1]) ? !last_r : pv[1];
        take = load && pv[grant];
        pready_in[0] = load && !grant;
        pready_in[1] = load && grant;
        lock_nxt = lock_r;
        owner_nxt = owner_r;
        last_nxt = last_r;
        if (take)
        begin
            owner_nxt = grant;
            lock_nxt = !peop[grant];
            if (peop[grant])
                last_nxt = grant;
        end
    end

    // Output byte stage and header decode at frame start
    always_comb
    begin
        ov_nxt = ov_r;
        odata_nxt = odata_r;
        osop_nxt = osop_r;
        oeop_nxt = oeop_r;
        ogrp_nxt = ogrp_r;
        desc_nxt = desc_r;
        tpid_nxt = tpid_r;
        if (load)
            ov_nxt = take;
        if (take)
        begin
            odata_nxt = pdata[grant];
            osop_nxt = psop[grant];
            oeop_nxt = peop[grant];
            ogrp_nxt = grant;
        end
        if (take && psop[grant])
        begin
            // Analyzer path zeroes every override field
            desc_nxt = 37'h0;
            if (byp)
            begin
                desc_nxt[36] = 1'b1;
                desc_nxt[35:9] = h[cfi_pkg::CFI_TSET_LSB +: 27];
                if (h[cfi_pkg::CFI_TSET_CPU_BIT])
                    desc_nxt[8:1] = h[cfi_pkg::CFI_QMASK_LSB +: 8];
                desc_nxt[0] = h[cfi_pkg::CFI_TAGTYPE_BIT];
            end
            tpid_nxt = cfi_pkg::CFI_TPID_CTAG;
            if (byp && h[cfi_pkg::CFI_TAGTYPE_BIT])
                tpid_nxt = ctrl_r[cfi_pkg::CFI_CTRL_CUSTOM_BIT] ? stag_r :
                    cfi_pkg::CFI_TPID_STAG;
        end
    end

    // Tag, class and strip fields captured at frame start
    logic [20:0] tag_r, tag_nxt;
    always_comb
    begin
        tag_nxt = tag_r;
        if (take && psop[grant])
        begin
            tag_nxt = 21'h0;
            if (byp)
            begin
                tag_nxt[20:19] = h[cfi_pkg::CFI_STRIP_LSB +: 2];
                tag_nxt[18:16] = h[cfi_pkg::CFI_CLASS_LSB +: 3];
                tag_nxt[15:13] = h[cfi_pkg::CFI_PCP_LSB +: 3];
                tag_nxt[12] = h[cfi_pkg::CFI_DEI_BIT];
                tag_nxt[11:0] = h[cfi_pkg::CFI_VID_LSB +: 12];
            end
        end
    end

    // Frame and short-header counters, wrap at 255
    always_comb
    begin
        cnt0_nxt = cnt0_r;
        cnt1_nxt = cnt1_r;
        short_nxt = short_r + {7'h0, pshort[0]} + {7'h0, pshort[1]};
        if (take && peop[grant] && !grant)
            cnt0_nxt = cnt0_r + 8'h1;
        if (take && peop[grant] && grant)
            cnt1_nxt = cnt1_r + 8'h1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_r <= 1'b0;
            owner_r <= 1'b0;
            last_r <= 1'b1;
            ov_r <= 1'b0;
            odata_r <= 8'h0;
            osop_r <= 1'b0;
            oeop_r <= 1'b0;
            ogrp_r <= 1'b0;
            desc_r <= 37'h0;
            tpid_r <= cfi_pkg::CFI_TPID_CTAG;
            tag_r <= 21'h0;
            cnt0_r <= 8'h0;
            cnt1_r <= 8'h0;
            short_r <= 8'h0;
        end
        else
        begin
            lock_r <= lock_nxt;
            owner_r <= owner_nxt;
            last_r <= last_nxt;
            ov_r <= ov_nxt;
            odata_r <= odata_nxt;
            osop_r <= osop_nxt;
            oeop_r <= oeop_nxt;
            ogrp_r <= ogrp_nxt;
            desc_r <= desc_nxt;
            tpid_r <= tpid_nxt;
            tag_r <= tag_nxt;
            cnt0_r <= cnt0_nxt;
            cnt1_r <= cnt1_nxt;
            short_r <= short_nxt;
        end
    end

    // Core-facing outputs
    assign core_valid = ov_r;
    assign core_data = odata_r;
    assign core_sop = osop_r;
    assign core_eop = oeop_r;
    assign core_src_port = cfi_pkg::CFI_CORE_PORT;
    assign core_cpu_port = ogrp_r ? cfi_pkg::CFI_PORT_GRP1 :
        cfi_pkg::CFI_PORT_GRP0;
    assign core_bypass = desc_r[36];
    assign core_use_analyzer = !desc_r[36];
    assign core_target_port_set = desc_r[35:9];
    assign core_queue_mask = desc_r[8:1];
    assign core_tag_s = desc_r[0];
    assign core_tpid = tpid_r;
    assign core_tag_strip_count = tag_r[20:19];
    assign core_rewrite_off = desc_r[36] &&
        (tag_r[20:19] == cfi_pkg::CFI_STRIP_NOREWRITE);
    assign core_service_class_override = tag_r[18:16];
    assign core_pcp = tag_r[15:13];
    assign core_dei = tag_r[12];
    assign core_vid = tag_r[11:0];

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    src_port_fixed_a:
        assert property (core_valid |-> core_src_port == 5'h1a)
        else $error("source port not 26");
    prio_write_a:
        assert property (wr_en && paddr == 12'h000 |=>
            cpu_source_priority == $past(pwdata[2]))
        else $error("priority level did not follow write");
    analyzer_zero_a:
        assert property (core_valid && core_use_analyzer |->
            core_target_port_set == 27'h0 &&
            core_service_class_override == 3'h0)
        else $error("override fields leak on analyzer path");
    queue_gate_a:
        assert property (core_valid && core_queue_mask != 8'h0 |->
            core_bypass && core_target_port_set[26])
        else $error("queue mask without bypass to CPU");
    rewrite_off_a:
        assert property (core_valid |-> core_rewrite_off ==
            (core_bypass && core_tag_strip_count == 2'h3))
        else $error("rewrite disable wrong");
    ctag_tpid_a:
        assert property (core_valid && !core_tag_s |-> core_tpid == 16'h8100)
        else $error("C-tag TPID wrong");
    bypass_flag_a:
        assert property (core_valid |-> core_bypass != core_use_analyzer)
        else $error("bypass and analyzer flags agree");
    stall_hold_a:
        assert property (core_valid && !core_ready |=> core_valid &&
            $stable(core_data) && $stable(core_sop))
        else $error("output changed under stall");
    desc_stable_a:
        assert property (core_valid && !core_sop |->
            $stable(core_target_port_set) && $stable(core_vid))
        else $error("descriptor changed mid frame");

    bypass_frame_c: cover property (core_valid && core_sop && core_bypass);
    analyzer_frame_c: cover property (core_valid && core_sop && !core_bypass);
    contend_c: cover property (pv[0] && pv[1] && !lock_r);
    stall_c: cover property (core_valid && !core_ready ##1 core_ready);

endmodule : cfi_top

// ---- tb/cfi_cpu_model.sv ----
// CPU writer model: sends one frame into an injection group on go.
// Assumes a valid/ready byte stream sampled on the rising pclk edge.
`timescale 1ns/10ps
module cfi_cpu_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic [63:0] hdr,
    input wire logic [7:0] len,
    output logic valid = 1'b0,
    input wire logic ready,
    output logic [7:0] data = 8'h0,
    output logic sop = 1'b0,
    output logic eop = 1'b0
);
    int idx;

    // Header MSB first, then a counting body
    function automatic logic [7:0] byte_at(int k);
        if (k < 8)
            return hdr[63 - 8 * k -: 8];
        return 8'ha0 + 8'(k);
    endfunction : byte_at

    // Hold each byte until taken; idle data keeps changing
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            valid <= 1'b0;
            idx <= 0;
        end
        else if (valid && ready && eop)
        begin
            valid <= 1'b0;
            data <= ~data;
        end
        else if ((valid && ready) || (!valid && go))
        begin
            valid <= 1'b1;
            idx <= valid ? idx + 1 : 0;
            data <= byte_at(valid ? idx + 1 : 0);
            sop <= !valid;
            eop <= (valid ? idx + 1 : 0) == 7 + int'(len);
        end
        else if (!valid)
            data <= ~data;
    end
endmodule : cfi_cpu_model

// ---- tb/tb.sv ----
// Bench for the CPU injection path: APB set-up, frames on both groups.
// Assumes cfi_top and the writer model cfi_cpu_model.
`timescale 1ns/10ps
module tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, core_ready = 1'b1, go0 = 1'b0, go1 = 1'b0;
    logic stall = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [63:0] fhdr = 64'h0;
    logic pready, pslverr, inj0_valid, inj0_ready, inj0_sop, inj0_eop;
    logic inj1_valid, inj1_ready, inj1_sop, inj1_eop, core_valid, core_sop;
    logic core_eop, core_use_analyzer, core_bypass, core_rewrite_off;
    logic core_tag_s, core_dei, cpu_source_priority;
    logic [7:0] inj0_data, inj1_data, core_data, core_queue_mask;
    logic [7:0] flen = 8'h4;
    logic [4:0] core_src_port, core_cpu_port;
    logic [26:0] core_target_port_set;
    logic [2:0] core_service_class_override, core_pcp;
    logic [1:0] core_tag_strip_count;
    logic [15:0] core_tpid;
    logic [15:0] stpid = 16'h88a8;
    logic [11:0] core_vid;
    int bad_count = 0, check_count = 0;

    cfi_top dut (.*);
    cfi_cpu_model cpu0 (.pclk(pclk), .presetn(presetn), .go(go0),
        .hdr(fhdr), .len(flen), .valid(inj0_valid), .ready(inj0_ready),
        .data(inj0_data), .sop(inj0_sop), .eop(inj0_eop));
    cfi_cpu_model cpu1 (.pclk(pclk), .presetn(presetn), .go(go1),
        .hdr(fhdr), .len(flen), .valid(inj1_valid), .ready(inj1_ready),
        .data(inj1_data), .sop(inj1_sop), .eop(inj1_eop));

    // Clock and a core sink that stalls every other cycle while stall is set
    always #25 pclk = ~pclk;
    always @(posedge pclk)
        core_ready <= stall ? ~core_ready : 1'b1;

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer, request held until pready
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            bad_count++;
            give_verdict();
        end
        @(posedge pclk);
    endtask : apb

    // Send a frame, check descriptor and stripped body on the core side
    task automatic run_frame(input logic g, input logic [63:0] h);
        logic b;
        int n;
        int k;
        b = h[63];
        fhdr <= h;
        if (g)
            go1 <= 1'b1;
        else
            go0 <= 1'b1;
        @(posedge pclk);
        go0 <= 1'b0;
        go1 <= 1'b0;
        k = 0;
        n = 0;
        while (k < int'(flen) && n < 400)
        begin
            @(posedge pclk);
            n++;
            if (core_valid === 1'b1 && core_ready === 1'b1)
            begin
                if (k == 0)
                begin
                    chk({core_bypass, core_use_analyzer},
                        {b, !b});
                    chk(core_src_port, 5'h1a);
                    chk(core_cpu_port, g ? 5'h1b : 5'h1a);
                    chk(core_target_port_set, b ? h[58:32] : 27'h0);
                    chk(core_queue_mask,
                        b && h[58] ? h[27:20] : 8'h0);
                    chk(core_service_class_override,
                        b ? h[19:17] : 3'h0);
                    chk(core_tag_strip_count, b ? h[29:28] : 2'h0);
                    chk(core_rewrite_off, b && h[29:28] == 2'h3);
                    chk({core_tag_s, core_tpid},
                        b && h[16] ? {1'b1, stpid} : 17'h08100);
                    chk({core_pcp, core_dei, core_vid},
                        b ? h[15:0] : 16'h0);
                end
                chk({core_sop, core_eop, core_data}, {k == 0,
                    k == int'(flen) - 1, 8'ha8 + 8'(k)});
                k++;
            end
        end
        if (k < int'(flen))
        begin
            bad_count++;
            give_verdict();
        end
    endtask : run_frame

    task automatic t_regs;
        logic [31:0] q;
        logic e;
        apb(1'b0, 12'h000, 32'h0, q, e);
        chk(q, 32'h0);
        apb(1'b0, 12'h004, 32'h0, q, e);
        chk(q, 32'h88a8);
        apb(1'b1, 12'h008, 32'hffffffff, q, e);
        apb(1'b0, 12'h008, 32'h0, q, e);
        chk(q, 32'h0);
        apb(1'b0, 12'h00c, 32'h0, q, e);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, 12'h000, 32'h7, q, e);
        chk(cpu_source_priority, 1'b1);
        apb(1'b1, 12'h000, 32'h3, q, e);
        chk(cpu_source_priority, 1'b0);
    endtask : t_regs

    task automatic t_bypass;
        run_frame(1'b0, {1'b1, 4'h0, 27'h4000005, 4'h1, 8'h5a, 3'h5,
            1'b0, 3'h6, 1'b1, 12'h123});
    endtask : t_bypass

    task automatic t_nocpu;
        logic [63:0] h;
        logic [31:0] q;
        logic e;
        h = {1'b1, 4'hf, 27'h0000011, 4'hf, 8'hff, 3'h2,
            1'b1, 3'h1, 1'b0, 12'hffe};
        run_frame(1'b1, h);
        // Custom S-tag TPID from the STAG register
        apb(1'b1, 12'h004, 32'h9100, q, e);
        apb(1'b1, 12'h000, 32'hb, q, e);
        stpid = 16'h9100;
        run_frame(1'b0, h);
    endtask : t_nocpu

    task automatic t_analyzer;
        stall <= 1'b1;
        run_frame(1'b1, {1'b0, 4'h0, 27'h7ffffff, 4'h2, 8'h81, 3'h7,
            1'b1, 3'h7, 1'b1, 12'h0a5});
        stall <= 1'b0;
    endtask : t_analyzer

    task automatic t_short;
        logic [31:0] q;
        logic e;
        int seen;
        seen = 0;
        flen <= 8'h0;
        fhdr <= {1'b1, 63'h0};
        go0 <= 1'b1;
        @(posedge pclk);
        go0 <= 1'b0;
        repeat (30)
        begin
            @(posedge pclk);
            if (core_valid !== 1'b0)
                seen++;
        end
        chk(seen, 32'h0);
        apb(1'b0, 12'h008, 32'h0, q, e);
        chk(q, 32'h00010202);
    endtask : t_short

    // Reset, then the scenarios in turn
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_bypass();
        t_nocpu();
        t_analyzer();
        t_short();
        give_verdict();
    end
endmodule : tb
